/* File: hdl/cycle_sched_regs.vh */
// Constants for the fieldbus master cycle scheduler
`ifndef CYCLE_SCHED_REGS_VH
`define CYCLE_SCHED_REGS_VH

// Slave table size
`define SLAVE_COUNT 8
`define SLAVE_IDX_W 3

// Transaction kinds on the slave request port
`define KIND_PROBE 2'h0
`define KIND_DATA 2'h1
`define KIND_DIAG 2'h2

// Target rotation time in microseconds and clock rate in MHz
`define TARGET_ROTATION_TIME_US 10000
`define CLK_MHZ 100

// Number of masters sharing the bus by default
`define MASTER_COUNT 2

`endif

/* File: hdl/fieldbus_master_cycle_scheduler.v */
// Cycle sequencer of a fieldbus master: connect, data, diagnostics, token passing
// Notes on behaviour
// - At power-up probe every configured slave; data cycle serves only reachable ones.
// - In steady state, reconnect each unreachable slave individually.
// - Data cycle sends outputs to and reads inputs from each reachable slave.
// - Run diagnostics only when some slave's diagnostic report changed.
// - With several masters, at most one holds bus access at once.
// - Token circulates to every master in turn, endlessly.
// - Without the token, issue no slave transaction.
// - Full token rotation stays within the target rotation time; code cuts its turn only in S_PICK, so a transaction in flight may overrun it.
// - Power-up runs the program once from connecting cycle, then steady state.
// - Steady state repeats; connecting cycle reruns only after a reset.
// - After data, diagnostics and reconnection, pass the token when several masters exist.
`timescale 1ns/1ps
`default_nettype none
`include "cycle_sched_regs.vh"

module fieldbus_master_cycle_scheduler #(
	parameter [31:0] ROTATION_CYCLES = `TARGET_ROTATION_TIME_US * `CLK_MHZ,
	parameter [31:0] MASTERS = `MASTER_COUNT
) (
	input wire clk,
	input wire rst_n,
	input wire [`SLAVE_COUNT-1:0] configured,
	input wire multi_master,
	input wire token_in,
	input wire txn_done,
	input wire txn_ok,
	input wire diag_event,
	input wire [`SLAVE_IDX_W-1:0] diag_slave,
	output reg txn_start,
	output reg [1:0] txn_kind,
	output reg [`SLAVE_IDX_W-1:0] txn_slave,
	output reg token_out,
	output reg has_token,
	output reg [`SLAVE_COUNT-1:0] reachable,
	output reg powerup_done,
	output reg rotation_overrun
);
	// -----------------------------------------------------------------
	// Constants
	// -----------------------------------------------------------------
	localparam [31:0] HOLD_CYCLES = (ROTATION_CYCLES / MASTERS < 32'h1) ?
		32'h1 : ROTATION_CYCLES / MASTERS;

	localparam [2:0] S_WAIT_TOKEN = 3'h0;
	localparam [2:0] S_PICK = 3'h1;
	localparam [2:0] S_ISSUE = 3'h2;
	localparam [2:0] S_WAIT_DONE = 3'h3;
	localparam [2:0] S_PASS = 3'h4;

	localparam [1:0] PH_CONNECT = 2'h0;
	localparam [1:0] PH_DATA = 2'h1;
	localparam [1:0] PH_DIAG = 2'h2;
	localparam [1:0] PH_RECONNECT = 2'h3;

	// -----------------------------------------------------------------
	// State
	// -----------------------------------------------------------------
	reg [2:0] state_reg;
	reg [1:0] phase_reg;
	reg [`SLAVE_IDX_W-1:0] idx_reg;
	wire [`SLAVE_COUNT-1:0] diag_pending;
	reg [31:0] hold_cnt_reg;
	reg [`SLAVE_COUNT-1:0] phase_flags;
	wire found;
	wire [`SLAVE_IDX_W-1:0] found_idx;
	wire budget_spent;

	// Slave set that the current phase walks through
	always @* begin
		case (phase_reg)
			PH_CONNECT: phase_flags = configured;
			PH_DATA: phase_flags = reachable & configured;
			PH_DIAG: phase_flags = reachable & diag_pending;
			PH_RECONNECT: phase_flags = configured & ~reachable;
			default: phase_flags = {`SLAVE_COUNT{1'b0}};
		endcase
	end

	next_slave_finder finder (
		.flags(phase_flags),
		.start(idx_reg),
		.found(found),
		.index(found_idx)
	);

	assign budget_spent = multi_master && (hold_cnt_reg >= HOLD_CYCLES);

	function [1:0] kind_of;
		input [1:0] phase;
		begin
			case (phase)
				PH_DATA: kind_of = `KIND_DATA;
				PH_DIAG: kind_of = `KIND_DIAG;
				default: kind_of = `KIND_PROBE;
			endcase
		end
	endfunction

	// -----------------------------------------------------------------
	// Diagnostic change flags
	// -----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < `SLAVE_COUNT; g = g + 1) begin : diag_flags
			reg bit_reg;
			wire set_bit = diag_event && (diag_slave == g);
			wire clr_bit = (state_reg == S_WAIT_DONE) && txn_done &&
				(phase_reg == PH_DIAG) && (txn_slave == g);
			assign diag_pending[g] = bit_reg;
			always @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					bit_reg <= 1'b0;
				end else if (set_bit) begin
					// new change kept even while clearing
					bit_reg <= 1'b1;
				end else if (clr_bit) begin
					bit_reg <= 1'b0;
				end
			end
		end
	endgenerate

	// -----------------------------------------------------------------
	// Sequencer
	// -----------------------------------------------------------------
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= S_WAIT_TOKEN;
			phase_reg <= PH_CONNECT;
			idx_reg <= {`SLAVE_IDX_W{1'b0}};
			hold_cnt_reg <= 32'h0;
			txn_start <= 1'b0;
			txn_kind <= `KIND_PROBE;
			txn_slave <= {`SLAVE_IDX_W{1'b0}};
			token_out <= 1'b0;
			has_token <= 1'b0;
			reachable <= {`SLAVE_COUNT{1'b0}};
			powerup_done <= 1'b0;
			rotation_overrun <= 1'b0;
		end else begin
			txn_start <= 1'b0;
			token_out <= 1'b0;
			if (has_token && multi_master) begin
				hold_cnt_reg <= hold_cnt_reg + 32'h1;
			end
			case (state_reg)
				S_WAIT_TOKEN: begin
					// wait for our turn; a lone master owns the bus
					if (token_in || !multi_master) begin
						has_token <= 1'b1;
						hold_cnt_reg <= 32'h0;
						idx_reg <= {`SLAVE_IDX_W{1'b0}};
						// first pass starts with the connecting cycle
						phase_reg <= powerup_done ? PH_DATA : PH_CONNECT;
						state_reg <= S_PICK;
					end
				end
				S_PICK: begin
					if (budget_spent) begin
						// cut the turn short to keep rotation bounded
						rotation_overrun <= 1'b1;
						state_reg <= S_PASS;
					end else if (found) begin
						idx_reg <= found_idx;
						state_reg <= S_ISSUE;
					end else begin
						idx_reg <= {`SLAVE_IDX_W{1'b0}};
						case (phase_reg)
							PH_CONNECT: begin
								powerup_done <= 1'b1;
								phase_reg <= PH_DATA;
							end
							PH_DATA: phase_reg <= PH_DIAG;
							PH_DIAG: phase_reg <= PH_RECONNECT;
							default: begin
								phase_reg <= PH_DATA;
								// token handed on after the work
								if (multi_master) begin
									state_reg <= S_PASS;
								end
							end
						endcase
					end
				end
				S_ISSUE: begin
					// only a token holder starts transactions
					if (has_token) begin
						txn_start <= 1'b1;
						txn_kind <= kind_of(phase_reg);
						txn_slave <= idx_reg;
						state_reg <= S_WAIT_DONE;
					end else begin
						state_reg <= S_WAIT_TOKEN;
					end
				end
				S_WAIT_DONE: begin
					if (txn_done) begin
						if (phase_reg == PH_DATA || phase_reg == PH_DIAG) begin
							if (!txn_ok) begin
								reachable[txn_slave] <= 1'b0;
							end
						end else begin
							reachable[txn_slave] <= txn_ok;
						end
						// Phase advance below may override this with a token pass
						state_reg <= S_PICK;
						if (idx_reg == `SLAVE_COUNT - 1) begin
							idx_reg <= {`SLAVE_IDX_W{1'b0}};
							phase_flags_done_advance(phase_reg);
						end else begin
							idx_reg <= idx_reg + 1'b1;
						end
					end
				end
				S_PASS: begin
					// release access before the next master gets it
					has_token <= 1'b0;
					token_out <= 1'b1;
					state_reg <= S_WAIT_TOKEN;
				end
				default: state_reg <= S_WAIT_TOKEN;
			endcase
		end
	end

	// Last slave of a phase: move to the following phase
	task phase_flags_done_advance;
		input [1:0] phase;
		begin
			case (phase)
				PH_CONNECT: begin
					powerup_done <= 1'b1;
					phase_reg <= PH_DATA;
				end
				PH_DATA: phase_reg <= PH_DIAG;
				PH_DIAG: phase_reg <= PH_RECONNECT;
				default: begin
					phase_reg <= PH_DATA;
					if (multi_master) begin
						state_reg <= S_PASS;
					end
				end
			endcase
		end
	endtask
endmodule // fieldbus_master_cycle_scheduler

`default_nettype wire

/* File: hdl/next_slave_finder.v */
// Finds the first flagged slave at or above a start index
`timescale 1ns/1ps
`default_nettype none
`include "cycle_sched_regs.vh"

module next_slave_finder (
	input wire [`SLAVE_COUNT-1:0] flags,
	input wire [`SLAVE_IDX_W-1:0] start,
	output reg found,
	output reg [`SLAVE_IDX_W-1:0] index
);
	integer i;

	always @* begin
		found = 1'b0;
		index = {`SLAVE_IDX_W{1'b0}};
		for (i = `SLAVE_COUNT - 1; i >= 0; i = i - 1) begin
			if (flags[i] && (i >= start)) begin
				found = 1'b1;
				index = i[`SLAVE_IDX_W-1:0];
			end
		end
	end
endmodule // next_slave_finder

`default_nettype wire

/* File: test/sched_monitor.sv */
// Port checker of the cycle scheduler
`timescale 1ns/1ps
`default_nettype none
`include "cycle_sched_regs.vh"
module sched_monitor #(
	parameter [31:0] ROTATION_CYCLES = 200,
	parameter [31:0] MASTERS = 2
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [`SLAVE_COUNT-1:0] configured,
	input wire logic multi_master,
	input wire logic token_in,
	input wire logic txn_done,
	input wire logic txn_ok,
	input wire logic txn_start,
	input wire logic [1:0] txn_kind,
	input wire logic [`SLAVE_IDX_W-1:0] txn_slave,
	input wire logic token_out,
	input wire logic has_token,
	input wire logic [`SLAVE_COUNT-1:0] reachable,
	input wire logic powerup_done
);
	logic pend_reg;
	logic [15:0] hold_reg;
	wire logic tdone = txn_done && pend_reg;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pend_reg <= 1'b0;
			hold_reg <= 16'h0000;
		end else begin
			pend_reg <= txn_start | (pend_reg & ~txn_done);
			hold_reg <= has_token ? hold_reg + 16'h0001 : 16'h0000;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_no_token_txn: assert property (txn_start |-> has_token)
		else $error("transaction without token");
	a_pass_drops: assert property (token_out |-> !has_token && $past(has_token))
		else $error("token passed while held");
	a_served_reach: assert property (txn_start && txn_kind != `KIND_PROBE
		|-> reachable[txn_slave])
		else $error("unreachable slave served");
	a_probe_target: assert property (txn_start && txn_kind == `KIND_PROBE
		|-> configured[txn_slave] && !reachable[txn_slave])
		else $error("bad probe target");
	a_ok_joins: assert property (tdone && txn_ok && txn_kind == `KIND_PROBE
		|=> reachable[txn_slave])
		else $error("answering slave not joined");
	a_fail_drops: assert property (tdone && !txn_ok |=> !reachable[txn_slave])
		else $error("failed slave kept");
	a_one_txn: assert property (pend_reg |-> !txn_start)
		else $error("second outstanding transaction");
	a_powerup_probe: assert property (txn_start && !powerup_done |-> txn_kind == `KIND_PROBE)
		else $error("non probe before power-up done");
	a_turn_budget: assert property (multi_master
		|-> hold_reg < ROTATION_CYCLES / MASTERS + 64)
		else $error("turn too long");
	a_token_grant: assert property (multi_master && $rose(has_token) |-> $past(token_in))
		else $error("token taken without grant");
	c_pass: cover property (token_out);
	c_diag: cover property (txn_start && txn_kind == `KIND_DIAG);
	c_fail: cover property (tdone && !txn_ok);
endmodule // sched_monitor
bind fieldbus_master_cycle_scheduler sched_monitor #(.ROTATION_CYCLES(ROTATION_CYCLES),
	.MASTERS(MASTERS)) mon (.clk(clk), .rst_n(rst_n), .configured(configured),
	.multi_master(multi_master), .token_in(token_in), .txn_done(txn_done), .txn_ok(txn_ok),
	.txn_start(txn_start), .txn_kind(txn_kind), .txn_slave(txn_slave), .token_out(token_out),
	.has_token(has_token), .reachable(reachable), .powerup_done(powerup_done));
`default_nettype wire

/* File: test/sched_partner.sv */
// Model of the bus slaves and one peer master
`timescale 1ns/1ps
`default_nettype none
module fieldbus_partner (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic txn_start,
	input wire logic [2:0] txn_slave,
	input wire logic [7:0] alive,
	input wire logic [3:0] delay,
	input wire logic token_out,
	input wire logic multi_master,
	output logic txn_done,
	output logic txn_ok,
	output logic token_in
);
	logic [3:0] cnt_reg;
	logic busy_reg;
	logic [4:0] tok_reg;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			{txn_done, txn_ok, token_in, busy_reg, cnt_reg} <= 8'h00;
			tok_reg <= 5'h03;
		end else begin
			txn_done <= 1'b0;
			txn_ok <= ~txn_ok;
			token_in <= 1'b0;
			if (txn_start) begin
				busy_reg <= 1'b1;
				cnt_reg <= delay;
			end else if (busy_reg && cnt_reg == 4'h0) begin
				busy_reg <= 1'b0;
				txn_done <= 1'b1;
				txn_ok <= alive[txn_slave];
			end else if (busy_reg) begin
				cnt_reg <= cnt_reg - 4'h1;
			end
			// peer holds the token, then returns it
			if (token_out)
				tok_reg <= 5'h10;
			else if (tok_reg != 5'h00)
				tok_reg <= tok_reg - 5'h01;
			token_in <= multi_master && tok_reg == 5'h01;
		end
	end
endmodule // fieldbus_partner
`default_nettype wire

/* File: test/test_fieldbus_master_cycle_scheduler.sv */
// Self-checking bench of the cycle scheduler
`timescale 1ns/1ps
`default_nettype none
`include "cycle_sched_regs.vh"
module test_fieldbus_master_cycle_scheduler;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] configured = 8'hb5;
	logic multi_master = 1'b0;
	logic diag_event = 1'b0;
	logic [2:0] diag_slave = 3'h0;
	logic [7:0] alive = 8'h35;
	logic [3:0] delay = 4'h0;
	logic token_in, txn_done, txn_ok, txn_start, token_out, has_token, powerup_done, overrun;
	logic [1:0] txn_kind;
	logic [2:0] txn_slave;
	logic [7:0] reachable, a;
	logic [31:0] seed = 32'hef2b;
	int n_errors = 0, n_tests = 0, n_diag = 0, n_tok = 0, k;
	always #5 clk = ~clk;
	fieldbus_master_cycle_scheduler #(.ROTATION_CYCLES(200), .MASTERS(2)) dut (.clk(clk),
		.rst_n(rst_n), .configured(configured), .multi_master(multi_master),
		.token_in(token_in), .txn_done(txn_done), .txn_ok(txn_ok), .diag_event(diag_event),
		.diag_slave(diag_slave), .txn_start(txn_start), .txn_kind(txn_kind),
		.txn_slave(txn_slave), .token_out(token_out), .has_token(has_token),
		.reachable(reachable), .powerup_done(powerup_done), .rotation_overrun(overrun));
	fieldbus_partner far (.clk(clk), .rst_n(rst_n), .txn_start(txn_start),
		.txn_slave(txn_slave), .alive(alive), .delay(delay), .token_out(token_out),
		.multi_master(multi_master), .txn_done(txn_done), .txn_ok(txn_ok), .token_in(token_in));
	always @(posedge clk) begin
		if (txn_start === 1'b1 && txn_kind === `KIND_DIAG) n_diag <= n_diag + 1;
		if (token_out === 1'b1) n_tok <= n_tok + 1;
	end
	function automatic logic [31:0] xorshift(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	function automatic logic [7:0] exp_reach(input logic [7:0] live);
		return configured & live;
	endfunction
	task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task results;
		$display("checks %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task do_reset(input logic mm);
		@(posedge clk) rst_n <= 1'b0;
		multi_master <= mm;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
	endtask
	task wait_reach(input logic [7:0] exp);
		for (k = 0; k < 4000 && reachable !== exp; k++) @(negedge clk);
		check("reachable", reachable, exp);
	endtask
	initial begin
		do_reset(1'b0);
		wait_reach(exp_reach(8'h35));
		for (k = 0; k < 400 && powerup_done !== 1'b1; k++) @(negedge clk);
		check("powerup_done", {7'h0, powerup_done}, 8'h01);
		$display("test powerup done");
		for (int r = 0; r < 6; r++) begin
			seed = xorshift(seed);
			a = (r == 0) ? 8'h00 : (r == 5) ? 8'hff : seed[7:0];
			@(posedge clk);
			alive <= a;
			delay <= seed[11:8];
			wait_reach(exp_reach(a));
		end
		check("diag quiet", n_diag[7:0], 8'h00);
		$display("test reconnect done");
		@(posedge clk);
		diag_slave <= 3'h2;
		diag_event <= 1'b1;
		@(posedge clk) diag_event <= 1'b0;
		for (k = 0; k < 2000 && n_diag == 0; k++) @(negedge clk);
		check("diag slave", {5'h0, txn_slave}, 8'h02);
		$display("test diag done");
		delay <= 4'h0;
		do_reset(1'b1);
		wait_reach(exp_reach(8'hff));
		for (k = 0; k < 4000 && n_tok < 3; k++) @(negedge clk);
		check("token passes", {7'h0, n_tok >= 3}, 8'h01);
		check("overrun", {7'h0, overrun}, 8'h00);
		$display("test token done");
		@(posedge clk) delay <= 4'hf;
		for (k = 0; k < 3000 && overrun !== 1'b1; k++) @(negedge clk);
		check("overrun set", {7'h0, overrun}, 8'h01);
		for (k = 0; k < 3000 && n_tok < 6; k++) @(negedge clk);
		check("token after cut", {7'h0, n_tok >= 6}, 8'h01);
		$display("test budget done");
		results();
	end
endmodule // test_fieldbus_master_cycle_scheduler
`default_nettype wire
